//--- crf_pkg.sv
// Package for the receive acceptance filter: register map, field layout, reset values, states and state record
package crf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PENDING = 8'h00;
   localparam logic [7:0] OFS_LOST = 8'h04;
   localparam logic [7:0] OFS_REMOTE = 8'h08;
   localparam logic [7:0] OFS_LMASK = 8'h0C;
   localparam logic [7:0] OFS_GMASK = 8'h10;
   localparam logic [7:0] OFS_DIR = 8'h14;
   localparam logic [7:0] OFS_AUTO = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
   localparam logic [7:0] OFS_TXREQ = 8'h20;
   localparam logic [1:0] OFS_MB_ID_TOP = 2'h1;
   localparam logic [0:0] OFS_MB_DATA_TOP = 1'h1;
   // Field positions
   localparam int MB_IDE_BIT = 31;
   localparam int MB_MSEL_BIT = 30;
   localparam int MASK_IGN_BIT = 31;
   localparam int STD_ID_LSB = 18;
   localparam logic [3:0] LAST_MB = 4'hF;
   // Writable bits
   localparam logic [31:0] MASK_WMASK = 32'h9FFF_FFFF;
   localparam logic [31:0] MB_ID_WMASK = 32'hDFFF_FFFF;
   // Reset values
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [14:0] DIR_RST = 15'h7FFF;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Gray along idle, scan, flag, write
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SCAN = 2'b01,
      ST_FLAG = 2'b11,
      ST_WRITE = 2'b10
   } crf_state_t;

   typedef struct packed {
      crf_state_t state;
      logic [3:0] idx;
      logic f_ide;
      logic f_rem;
      logic [28:0] f_id;
      logic [63:0] f_data;
      logic [15:0] pend;
      logic [15:0] lost;
      logic [15:0] remote_frame_pending_flags;
      logic [31:0] lmask;
      logic [31:0] gmask;
      logic [14:0] dir_rx;
      logic [14:0] auto_reply;
      logic [14:0] tx_req;
      logic [15:0] irq_en;
      logic [15:0][31:0] mb_id;
      logic [15:0][63:0] mb_data;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } crf_regs_t;
endpackage : crf_pkg

//--- crf_rx_filter.sv
// Receive status flags and acceptance filter for a sixteen-mailbox CAN controller
//
// Behaviour
// [RULE_01] A mailbox receiving a new message sets its pending bit.
// [RULE_02] Arrival while pending sets lost first, then the message is overwritten.
// [RULE_03] Writing one to pending bit n clears pending and lost of mailbox n.
// [RULE_04] Overload (arrival while still pending) sets the mailbox lost bit.
// [RULE_05] Lost bits are set by hardware only, cleared only through the pending register.
// [RULE_06] Reset clears pending, lost, remote-pending flags and the local mask.
// [RULE_07] Remote frames are compared with mailbox identifiers using the selected mask.
// [RULE_08] Remote match on a transmit mailbox with auto-reply sets its transmit request.
// [RULE_09] Remote match on a receive mailbox stores it, sets pending and remote-pending.
// [RULE_10] Comparison stops at the first matching mailbox.
// [RULE_11] Writing one to pending bit n clears remote-pending n; zero leaves it.
// [RULE_12] A data frame overwriting a stored remote frame clears remote-pending.
// [RULE_13] Mailboxes 0 to 14 use the global mask only when their mask select is set.
// [RULE_14] Mailbox 15 is tried only when mailboxes 0 to 14 all missed.
// [RULE_15] Mailbox 15 uses the local mask when selected; global mask never applies.
// [RULE_16] Mask bit one accepts any incoming bit; zero demands equality.
// [RULE_17] Extension-ignore zero: stored extension bit picks format; one: both formats pass.
// [RULE_18] With extension-ignore, extended frames use 29 bits, standard use bits 28 to 18.
// [RULE_19] Extended frames compare extension plus 29 bits; standard extension plus 11 bits.
// [RULE_20] The acceptance code is the identifier word of the mailbox being examined.
// [RULE_21] A set pending flag raises the receive interrupt when enabled.
// [RULE_22] A frame matching no mailbox is dropped with no state change.
// [RULE_23] Writing zero to a pending bit changes no flag of that mailbox.
// [RULE_24] Mask bits 30 and 29 read zero and ignore writes.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module crf_rx_filter (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // AXI4-Lite write address
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic [2:0] i_s_axi_awprot,
   // AXI4-Lite write data
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   // AXI4-Lite write response
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   // AXI4-Lite read address
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic [2:0] i_s_axi_arprot,
   // AXI4-Lite read data
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   // Received frame from the bit-stream logic
   input wire logic i_frame_valid,
   output logic o_frame_ready,
   input wire logic i_frame_ide,
   input wire logic i_frame_remote,
   input wire logic [28:0] i_frame_id,
   input wire logic [63:0] i_frame_data,
   // Status towards the rest of the controller
   output logic [14:0] o_tx_request_set,
   output logic o_rx_irq
);

   logic [1:0] rst_sync_r;
   logic rst_n;
   crf_pkg::crf_regs_t r;
   crf_pkg::crf_regs_t n;

   // Mask-aware identifier compare against one mailbox word
   function automatic logic id_match(input logic f_ide, input logic [28:0] f_id, input logic [31:0] code,
                                     input logic use_m, input logic [31:0] m);
      logic [28:0] care;
      logic ign;
      logic [28:0] diff;
      care = use_m ? ~m[28:0] : '1; // [RULE_16]
      ign = use_m & m[crf_pkg::MASK_IGN_BIT];
      diff = (f_id ^ code[28:0]) & care; // [RULE_20]
      if (!ign && (f_ide != code[crf_pkg::MB_IDE_BIT])) begin
         id_match = 1'b0; // [RULE_17] [RULE_19]
      end else if (f_ide) begin
         id_match = (diff == 29'h0000_0000); // [RULE_18] [RULE_19]
      end else begin
         id_match = (diff[28:crf_pkg::STD_ID_LSB] == 11'h000); // [RULE_18] [RULE_19]
      end
   endfunction : id_match

   // Byte-strobe merge of a write into a register, limited to writable bits
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] st, input logic [31:0] wm);
      logic [31:0] be;
      be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
      strb_merge = (old & ~be) | (wd & be);
   endfunction : strb_merge

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_comb begin
      logic hit;
      logic cand;
      logic use_m;
      logic [31:0] m;
      logic [15:0] clr;
      logic [3:0] be_w;
      logic wr_ok;
      logic rd_ok;
      logic [31:0] rd;
      logic [3:0] ri;
      logic [31:0] mg;
      n = r;
      mg = '0;
      hit = 1'b0;
      cand = 1'b0;
      use_m = 1'b0;
      m = '0;
      clr = '0;
      be_w = '0;
      wr_ok = 1'b0;
      rd_ok = 1'b0;
      rd = '0;
      ri = '0;

      // Write channel: address and data are taken in either order
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         n.aw_got = 1'b1;
         n.awaddr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         n.w_got = 1'b1;
         n.wdata = i_s_axi_wdata;
         n.wstrb = i_s_axi_wstrb;
      end
      if (r.bvalid && i_s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (r.aw_got && r.w_got && !r.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         wr_ok = 1'b1;
         be_w = r.wstrb;
         if (r.awaddr[7:6] == crf_pkg::OFS_MB_ID_TOP) begin
            n.mb_id[r.awaddr[5:2]] = strb_merge(r.mb_id[r.awaddr[5:2]], r.wdata, be_w, crf_pkg::MB_ID_WMASK);
         end else if (r.awaddr[7] == crf_pkg::OFS_MB_DATA_TOP) begin
            wr_ok = 1'b0;
         end else begin
            case (r.awaddr)
               crf_pkg::OFS_PENDING: begin
                  // Only ones clear; zeros leave every flag alone
                  clr = r.wdata[15:0] & {{8{be_w[1]}}, {8{be_w[0]}}}; // [RULE_03] [RULE_11] [RULE_23]
               end
               crf_pkg::OFS_LOST: begin
                  wr_ok = 1'b1; // [RULE_05]
               end
               crf_pkg::OFS_REMOTE: begin
                  wr_ok = 1'b1;
               end
               crf_pkg::OFS_LMASK: begin
                  n.lmask = strb_merge(r.lmask, r.wdata, be_w, crf_pkg::MASK_WMASK); // [RULE_24]
               end
               crf_pkg::OFS_GMASK: begin
                  n.gmask = strb_merge(r.gmask, r.wdata, be_w, crf_pkg::MASK_WMASK); // [RULE_24]
               end
               crf_pkg::OFS_DIR: begin
                  mg = strb_merge({17'h0_0000, r.dir_rx}, r.wdata, be_w, 32'h0000_7FFF);
                  n.dir_rx = mg[14:0];
               end
               crf_pkg::OFS_AUTO: begin
                  mg = strb_merge({17'h0_0000, r.auto_reply}, r.wdata, be_w, 32'h0000_7FFF);
                  n.auto_reply = mg[14:0];
               end
               crf_pkg::OFS_IRQ_EN: begin
                  mg = strb_merge({16'h0000, r.irq_en}, r.wdata, be_w, 32'h0000_FFFF);
                  n.irq_en = mg[15:0];
               end
               crf_pkg::OFS_TXREQ: begin
                  n.tx_req = r.tx_req & ~(r.wdata[14:0] & {{7{be_w[1]}}, {8{be_w[0]}}});
               end
               default: begin
                  wr_ok = 1'b0;
               end
            endcase
         end
         n.bresp = wr_ok ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
      end

      // Host clears first; hardware sets below win in the same cycle
      n.pend = r.pend & ~clr;
      n.lost = r.lost & ~clr;
      n.remote_frame_pending_flags = r.remote_frame_pending_flags & ~clr;

      // Read channel
      if (r.rvalid && i_s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         rd_ok = 1'b1;
         ri = i_s_axi_araddr[5:2];
         if (i_s_axi_araddr[7:6] == crf_pkg::OFS_MB_ID_TOP) begin
            rd = r.mb_id[ri];
         end else if (i_s_axi_araddr[7] == crf_pkg::OFS_MB_DATA_TOP) begin
            rd = i_s_axi_araddr[2] ? r.mb_data[i_s_axi_araddr[6:3]][63:32] : r.mb_data[i_s_axi_araddr[6:3]][31:0];
         end else begin
            case (i_s_axi_araddr)
               crf_pkg::OFS_PENDING: rd = {16'h0000, r.pend};
               crf_pkg::OFS_LOST: rd = {16'h0000, r.lost};
               crf_pkg::OFS_REMOTE: rd = {16'h0000, r.remote_frame_pending_flags};
               crf_pkg::OFS_LMASK: rd = r.lmask;
               crf_pkg::OFS_GMASK: rd = r.gmask;
               crf_pkg::OFS_DIR: rd = {16'h0000, 1'b1, r.dir_rx};
               crf_pkg::OFS_AUTO: rd = {17'h0_0000, r.auto_reply};
               crf_pkg::OFS_IRQ_EN: rd = {16'h0000, r.irq_en};
               crf_pkg::OFS_TXREQ: rd = {17'h0_0000, r.tx_req};
               default: rd_ok = 1'b0;
            endcase
         end
         n.rvalid = 1'b1;
         n.rdata = rd;
         n.rresp = rd_ok ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
      end

      // Frame walk: one mailbox per cycle, so a full miss costs sixteen cycles
      case (r.state)
         crf_pkg::ST_IDLE: begin
            n.idx = '0;
            if (i_frame_valid) begin
               n.f_ide = i_frame_ide;
               n.f_rem = i_frame_remote;
               n.f_id = i_frame_id;
               n.f_data = i_frame_data;
               n.state = crf_pkg::ST_SCAN;
            end
         end
         crf_pkg::ST_SCAN: begin
            if (r.idx == crf_pkg::LAST_MB) begin
               // Reached only after 0 to 14 missed
               cand = 1'b1; // [RULE_14]
               use_m = r.mb_id[r.idx][crf_pkg::MB_MSEL_BIT];
               m = r.lmask; // [RULE_15]
            end else begin
               // Transmit mailboxes only answer remote frames
               cand = r.dir_rx[r.idx] | r.f_rem; // [RULE_07]
               use_m = r.mb_id[r.idx][crf_pkg::MB_MSEL_BIT];
               m = r.gmask; // [RULE_13]
            end
            hit = cand & id_match(r.f_ide, r.f_id, r.mb_id[r.idx], use_m, m);
            if (hit) begin
               // First hit ends the walk
               if (r.idx == crf_pkg::LAST_MB || r.dir_rx[r.idx]) begin
                  n.state = crf_pkg::ST_FLAG; // [RULE_10]
               end else begin
                  if (r.auto_reply[r.idx]) begin
                     n.tx_req[r.idx] = 1'b1; // [RULE_08]
                  end
                  n.state = crf_pkg::ST_IDLE; // [RULE_10]
               end
            end else if (r.idx == crf_pkg::LAST_MB) begin
               n.state = crf_pkg::ST_IDLE; // [RULE_22]
            end else begin
               n.idx = r.idx + 4'h1;
            end
         end
         crf_pkg::ST_FLAG: begin
            // Lost is raised one cycle before the mailbox is overwritten
            if (r.pend[r.idx]) begin
               n.lost[r.idx] = 1'b1; // [RULE_02] [RULE_04]
            end
            n.state = crf_pkg::ST_WRITE;
         end
         crf_pkg::ST_WRITE: begin
            n.mb_id[r.idx] = {r.f_ide, r.mb_id[r.idx][crf_pkg::MB_MSEL_BIT], 1'b0, r.f_id}; // [RULE_02]
            n.mb_data[r.idx] = r.f_data; // [RULE_09]
            n.pend[r.idx] = 1'b1; // [RULE_01] [RULE_09]
            n.remote_frame_pending_flags[r.idx] = r.f_rem; // [RULE_09] [RULE_12]
            n.state = crf_pkg::ST_IDLE;
         end
         default: begin
            n.state = crf_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0; // [RULE_06]
         r.pend <= crf_pkg::FLAGS_RST; // [RULE_06]
         r.lost <= crf_pkg::FLAGS_RST; // [RULE_06]
         r.remote_frame_pending_flags <= crf_pkg::FLAGS_RST; // [RULE_06]
         r.lmask <= crf_pkg::MASK_RST; // [RULE_06]
         r.gmask <= crf_pkg::MASK_RST;
         r.dir_rx <= crf_pkg::DIR_RST;
         r.state <= crf_pkg::ST_IDLE;
      end else begin
         r <= n;
      end
   end

   // Handshakes
   assign o_s_axi_awready = !r.aw_got && !r.bvalid;
   assign o_s_axi_wready = !r.w_got && !r.bvalid;
   assign o_s_axi_arready = !r.rvalid;
   assign o_frame_ready = (r.state == crf_pkg::ST_IDLE);

   // Outputs taken from registers; the receive interrupt is pending AND enable, reduced by OR
   assign o_s_axi_bvalid = r.bvalid;
   assign o_s_axi_bresp = r.bresp;
   assign o_s_axi_rvalid = r.rvalid;
   assign o_s_axi_rdata = r.rdata;
   assign o_s_axi_rresp = r.rresp;
   assign o_tx_request_set = r.tx_req;
   assign o_rx_irq = |(r.pend & r.irq_en); // [RULE_21]

endmodule : crf_rx_filter

//--- crf_can_node.sv
// Behavioural bus node that hands received frames to the filter
`timescale 1ns/100ps
module crf_can_node (
   // Clock
   input wire logic i_core_clk,
   // Frame towards the filter
   output logic o_valid,
   input wire logic i_ready,
   output logic o_ide,
   output logic o_remote,
   output logic [28:0] o_id,
   output logic [63:0] o_data
);
   int stuck = 0;
   initial begin
      o_valid = 1'h0;
      o_ide = 1'h0;
      o_remote = 1'h0;
      o_id = 29'h0;
      o_data = 64'h0;
   end
   // Frame held whole until taken or for 40 cycles at most; released lines show the inverse so a late sample is caught
   task automatic send(input logic ide, input logic rem, input logic [28:0] id, input logic [63:0] d, input int gap);
      int n;
      repeat (gap) @(posedge i_core_clk);
      o_valid <= 1'h1;
      o_ide <= ide;
      o_remote <= rem;
      o_id <= id;
      o_data <= d;
      for (n = 0; n < 40; n++) begin
         @(posedge i_core_clk);
         if (i_ready) break;
      end
      if (n == 40) stuck++;
      o_valid <= 1'h0;
      o_ide <= ~ide;
      o_remote <= ~rem;
      o_id <= ~id;
      o_data <= ~d;
   endtask : send
endmodule : crf_can_node

//--- crf_rx_filter_properties.sv
// Timing checks of the frame walk, status outputs and bus answers
`timescale 1ns/100ps
module crf_rx_filter_chk (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Bus handshakes
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   // Frame side and status
   input wire logic i_frame_valid,
   input wire logic o_frame_ready,
   input wire logic [14:0] o_tx_request_set,
   input wire logic o_rx_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic take;
   assign take = i_frame_valid && o_frame_ready;
   AST_WALK_BUSY: assert property (take |=> !o_frame_ready)
      else $error("frame taken while walk not started");
   // Mailbox 15 is the last tried, so its answer bounds the walk
   AST_WALK_END: assert property (take |-> ##[2:20] o_frame_ready)
      else $error("mailbox walk did not finish in time");
   AST_IRQ_RISE: assert property ($rose(o_rx_irq) |-> $rose(o_frame_ready) || $rose(o_s_axi_bvalid))
      else $error("receive interrupt rose without a store or enable write");
   AST_IRQ_FALL: assert property ($fell(o_rx_irq) |-> $rose(o_s_axi_bvalid))
      else $error("receive interrupt fell without a host write");
   AST_TX_SET: assert property (|(o_tx_request_set & ~$past(o_tx_request_set)) |-> !$past(o_frame_ready))
      else $error("transmit request set outside a frame walk");
   AST_TX_CLR: assert property (|(~o_tx_request_set & $past(o_tx_request_set)) |-> $rose(o_s_axi_bvalid))
      else $error("transmit request cleared without a host write");
   AST_RD_ANS: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
      else $error("read answer late");
   AST_WR_ANS: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |-> ##2 o_s_axi_bvalid)
      else $error("write answer late");
   cover property (take);
   cover property ($rose(o_rx_irq));
   cover property ($rose(|o_tx_request_set));
endmodule : crf_rx_filter_chk
bind crf_rx_filter crf_rx_filter_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
   .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_arvalid(i_s_axi_arvalid),
   .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid), .i_frame_valid(i_frame_valid),
   .o_frame_ready(o_frame_ready), .o_tx_request_set(o_tx_request_set), .o_rx_irq(o_rx_irq));

//--- crf_rx_filter_bench.sv
// Bench of the receive filter: flag registers, mailbox hits, masks and auto-reply
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module crf_rx_filter_bench;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic awv = 1'h0, wv = 1'h0, bv_rdy = 1'h0, arv = 1'h0, rv_rdy = 1'h0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic awr, wrd, bv, arr, rv, fv, fr, fi, fm, irq;
   logic [1:0] bre, rre;
   logic [28:0] fid;
   logic [63:0] fd;
   logic [14:0] txq;
   int err_count = 0;
   int checked = 0;
   initial begin
      forever #4 clk = ~clk;
   end
   crf_rx_filter u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
      .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
      .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bv_rdy), .o_s_axi_bresp(bre),
      .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
      .o_s_axi_rvalid(rv), .i_s_axi_rready(rv_rdy), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rre),
      .i_frame_valid(fv), .o_frame_ready(fr), .i_frame_ide(fi), .i_frame_remote(fm), .i_frame_id(fid),
      .i_frame_data(fd), .o_tx_request_set(txq), .o_rx_irq(irq));
   crf_can_node u_node (.i_core_clk(clk), .o_valid(fv), .i_ready(fr), .o_ide(fi), .o_remote(fm), .o_id(fid),
      .o_data(fd));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic hang();
      `CHK("timeout", 1'h0, 1'h1)
      finish_test();
   endtask : hang
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awv <= 1'h1;
      awa <= a;
      wv <= 1'h1;
      wd <= d;
      bv_rdy <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'h0;
         if (wv && wrd) wv <= 1'h0;
         if (bv) break;
      end
      bv_rdy <= 1'h0;
      if (n == 50) hang();
      `CHK("bresp", er, bre)
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      int n;
      @(posedge clk);
      arv <= 1'h1;
      ara <= a;
      rv_rdy <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'h0;
         if (rv) break;
      end
      rv_rdy <= 1'h0;
      if (n == 50) hang();
      `CHK(nm, e, rdat)
      `CHK("rresp", 2'h0, rre)
   endtask : bus_rd
   // Offers a frame, then waits until the walk is over and its flags have landed
   task automatic frm(input logic ide, input logic rem, input logic [28:0] id, input logic [63:0] d, input int gap);
      int n;
      u_node.send(ide, rem, id, d, gap);
      if (u_node.stuck != 0) hang();
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         #1;
         if (fr) break;
      end
      if (n == 40) hang();
   endtask : frm
   function automatic logic [28:0] sid(input logic [10:0] s);
      return {s, 18'h00000};
   endfunction : sid
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      bus_rd(8'h00, 32'h0, "pending");
      bus_rd(8'h04, 32'h0, "lost");
      bus_rd(8'h08, 32'h0, "remote");
      bus_rd(8'h0C, 32'h0, "lmask");
      bus_wr(8'h0C, 32'hFFFF_FFFF, 2'h0);
      bus_rd(8'h0C, 32'h9FFF_FFFF, "lmask fixed bits");
      bus_wr(8'h0C, 32'h0, 2'h0);
      bus_wr(8'h3C, 32'h1, 2'h2);
      $display("register test done");
      bus_wr(8'h40, {3'h4, 29'h01ABCDE}, 2'h0);
      bus_wr(8'h44, {3'h0, sid(11'h123)}, 2'h0);
      bus_wr(8'h48, {3'h0, sid(11'h123)}, 2'h0);
      frm(1'h0, 1'h0, sid(11'h123), 64'h1122_3344_5566_7788, 1);
      bus_rd(8'h00, 32'h2, "first hit");
      frm(1'h0, 1'h0, sid(11'h123), 64'h99AA_BBCC_DDEE_FF00, 5);
      bus_rd(8'h04, 32'h2, "lost");
      bus_rd(8'h88, 32'hDDEE_FF00, "overwrite");
      bus_wr(8'h04, 32'hFFFF, 2'h0);
      bus_rd(8'h04, 32'h2, "lost kept");
      bus_wr(8'h00, 32'h0, 2'h0);
      bus_rd(8'h00, 32'h2, "zero write");
      bus_wr(8'h1C, 32'h2, 2'h0);
      `CHK("irq on", 1'h1, irq)
      bus_wr(8'h00, 32'h2, 2'h0);
      bus_rd(8'h04, 32'h0, "lost cleared");
      `CHK("irq off", 1'h0, irq)
      $display("overrun test done");
      frm(1'h0, 1'h1, sid(11'h123), 64'h0, 1);
      bus_rd(8'h08, 32'h2, "remote rx");
      bus_wr(8'h00, 32'h0, 2'h0);
      bus_rd(8'h08, 32'h2, "remote kept");
      frm(1'h0, 1'h0, sid(11'h123), 64'h5, 1);
      bus_rd(8'h08, 32'h0, "remote overwritten");
      bus_wr(8'h00, 32'h2, 2'h0);
      bus_wr(8'h14, 32'h7FF7, 2'h0);
      bus_wr(8'h18, 32'h8, 2'h0);
      bus_wr(8'h4C, {3'h0, sid(11'h055)}, 2'h0);
      frm(1'h0, 1'h1, sid(11'h055), 64'h0, 1);
      `CHK("auto reply", 15'h0008, txq)
      bus_wr(8'h20, 32'h8, 2'h0);
      `CHK("tx cleared", 15'h0000, txq)
      $display("remote test done");
      bus_wr(8'h10, {3'h0, sid(11'h00F)}, 2'h0);
      bus_wr(8'h50, {3'h2, sid(11'h200)}, 2'h0);
      bus_wr(8'h54, {3'h0, sid(11'h300)}, 2'h0);
      frm(1'h0, 1'h0, sid(11'h20A), 64'h0, 1);
      bus_rd(8'h00, 32'h10, "global mask");
      frm(1'h0, 1'h0, sid(11'h305), 64'h0, 1);
      bus_rd(8'h00, 32'h10, "no match");
      bus_wr(8'h0C, 32'h8000_FFFF, 2'h0);
      bus_wr(8'h7C, {3'h6, 29'h1234000}, 2'h0);
      frm(1'h0, 1'h0, sid(11'h048), 64'h0, 1);
      bus_rd(8'h00, 32'h8010, "local std");
      // The stored frame rewrote the mailbox 15 identifier, so restore it for the extended case
      bus_wr(8'h7C, {3'h6, 29'h1234000}, 2'h0);
      frm(1'h1, 1'h0, 29'h1234ABC, 64'h0, 1);
      bus_rd(8'h04, 32'h8000, "local ext");
      $display("mask test done");
      finish_test();
   end
endmodule : crf_rx_filter_bench
